// *** logic/fcs_defines.svh ***
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

// Register byte offsets
`define FCS_CTRL_OFS        8'h00
`define FCS_UPPER1_OFS      8'h04
`define FCS_LOWER1_OFS      8'h08
`define FCS_UPPER2_OFS      8'h0C
`define FCS_LOWER2_OFS      8'h10
`define FCS_MAXF_OFS        8'h14
`define FCS_STARTF_OFS      8'h18
`define FCS_JC1_OFS         8'h1C
`define FCS_JW1_OFS         8'h20
`define FCS_JC2_OFS         8'h24
`define FCS_JW2_OFS         8'h28
`define FCS_JC3_OFS         8'h2C
`define FCS_JW3_OFS         8'h30
`define FCS_HOLDF_OFS       8'h34
`define FCS_HOLDT_OFS       8'h38
`define FCS_RAMP_OFS        8'h3C
`define FCS_STATUS_OFS      8'h40

// Control register fields
`define FCS_CTRL_MOTOR2     0
`define FCS_CTRL_THIRD      1
`define FCS_CTRL_SRC_LO     2
`define FCS_CTRL_SRC_HI     3
`define FCS_CTRL_KDIR       4
`define FCS_CTRL_KRUN       5
`define FCS_CTRL_CURVE_LO   6
`define FCS_CTRL_CURVE_HI   7

// Status register fields
`define FCS_STAT_REV        16
`define FCS_STAT_HOLD       17
`define FCS_STAT_RUN        18

// Run command sources and keypad direction codes
`define FCS_SRC_TERMINAL    2'h1
`define FCS_SRC_KEYPAD      2'h2
`define FCS_KDIR_REVERSE    1'h1

// Ranges, in 0.01 Hz and 0.1 s units
`define FCS_FREQ_MAX        16'h9C40
`define FCS_WIDTH_MAX       16'h03E8
`define FCS_HOLDT_MAX       10'h258

// Reset values
`define FCS_CTRL_RST        8'h04
`define FCS_MAXF_RST        16'h1388
`define FCS_STARTF_RST      16'h0032
`define FCS_RAMP_RST        16'h000A

// Timing
`define FCS_CLK_NS          5
`define FCS_TICK_NS         1000000
`define FCS_HOLD_UNIT_TICKS 16'h0064

`endif

// *** logic/fcs_pkg.sv ***
`default_nettype none

package fcs_pkg;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RAMP = 2'b01,
    ST_HOLD = 2'b11
  } ramp_state_t;

  typedef struct packed {
    logic        fwd_meta;
    logic        fwd_sync;
    logic        rvs_meta;
    logic        rvs_sync;
    logic [7:0]  ctrl;
    logic [15:0] upper1;
    logic [15:0] lower1;
    logic [15:0] upper2;
    logic [15:0] lower2;
    logic [15:0] maxf;
    logic [15:0] startf;
    logic [15:0] jc1;
    logic [15:0] jw1;
    logic [15:0] jc2;
    logic [15:0] jw2;
    logic [15:0] jc3;
    logic [15:0] jw3;
    logic [15:0] holdf;
    logic [9:0]  holdt;
    logic [15:0] ramp;
    logic [17:0] tick_cnt;
    logic [15:0] hold_cnt;
    logic [15:0] out;
    logic        rev;
    logic        held;
    ramp_state_t st;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } shaper_state_t;

endpackage : fcs_pkg

`default_nettype wire

// *** logic/frequency_command_shaper.sv ***
`include "fcs_defines.svh"
`default_nettype none

module frequency_command_shaper
  import fcs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `FCS_TICK_NS / `FCS_CLK_NS
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Frequency command, same clock domain
  input  wire logic [15:0] i_freq_cmd,
  input  wire logic        i_cmd_at_min,
  input  wire logic        i_bipolar_sel,
  // Run command pins
  input  wire logic        i_forward_run_cmd,
  input  wire logic        i_reverse_run_cmd,
  // Output frequency generator
  output logic      [15:0] o_out_freq,
  output logic             o_out_reverse,
  output logic             o_running,
  output logic             o_accel_hold
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Moves a band-interior command to the nearer band edge
  function automatic logic [15:0] jump_fix(input logic [15:0] f, input logic [15:0] c, input logic [15:0] w);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = (c > w) ? c - w : 16'h0000;
    hi = c + w;
    jump_fix = f;
    if (c != 16'h0000 && w != 16'h0000 && f > lo && f < hi) begin
      jump_fix = (f >= c) ? hi : lo;
    end
  endfunction : jump_fix

  function automatic logic upper_ok(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] mx);
    upper_ok = (v == 16'h0000) || (v > lo && v <= mx);
  endfunction : upper_ok

  function automatic logic lower_ok(input logic [15:0] v, input logic [15:0] up, input logic [15:0] mx,
                                    input logic [15:0] sf);
    lower_ok = (v == 16'h0000) || (v >= sf && v <= ((up == 16'h0000) ? mx : up));
  endfunction : lower_ok

  function automatic logic [31:0] read_word(input logic [7:0] a, input shaper_state_t s);
    read_word = 32'h0000_0000;
    unique case (a)
      `FCS_CTRL_OFS:   read_word = {24'h00_0000, s.ctrl};
      `FCS_UPPER1_OFS: read_word = {16'h0000, s.upper1};
      `FCS_LOWER1_OFS: read_word = {16'h0000, s.lower1};
      `FCS_UPPER2_OFS: read_word = {16'h0000, s.upper2};
      `FCS_LOWER2_OFS: read_word = {16'h0000, s.lower2};
      `FCS_MAXF_OFS:   read_word = {16'h0000, s.maxf};
      `FCS_STARTF_OFS: read_word = {16'h0000, s.startf};
      `FCS_JC1_OFS:    read_word = {16'h0000, s.jc1};
      `FCS_JW1_OFS:    read_word = {16'h0000, s.jw1};
      `FCS_JC2_OFS:    read_word = {16'h0000, s.jc2};
      `FCS_JW2_OFS:    read_word = {16'h0000, s.jw2};
      `FCS_JC3_OFS:    read_word = {16'h0000, s.jc3};
      `FCS_JW3_OFS:    read_word = {16'h0000, s.jw3};
      `FCS_HOLDF_OFS:  read_word = {16'h0000, s.holdf};
      `FCS_HOLDT_OFS:  read_word = {22'h00_0000, s.holdt};
      `FCS_RAMP_OFS:   read_word = {16'h0000, s.ramp};
      `FCS_STATUS_OFS: read_word = {13'h0000, (s.st != ST_STOP), (s.st == ST_HOLD), s.rev, s.out};
      default:         read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= `FCS_STATUS_OFS);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // State

  shaper_state_t s_r;
  shaper_state_t s_nxt;

  logic [15:0] upper_sel;
  logic [15:0] lower_sel;
  logic        limit_on;
  logic        run_req;
  logic        want_rev;
  logic [15:0] cmd_lim;
  logic [15:0] target;
  logic [15:0] step;
  logic        tick;
  logic        wr_ok;
  logic        do_write;
  logic [15:0] wv;

  ////////////////////////////////////////////////////////////////////////////
  // Command shaping

  always_comb begin
    upper_sel = s_r.ctrl[`FCS_CTRL_MOTOR2] ? s_r.upper2 : s_r.upper1;
    lower_sel = s_r.ctrl[`FCS_CTRL_MOTOR2] ? s_r.lower2 : s_r.lower1;
    limit_on  = !s_r.ctrl[`FCS_CTRL_THIRD]
                && !(upper_sel == 16'h0000 && lower_sel == 16'h0000);

    // Run request and direction
    if (s_r.ctrl[`FCS_CTRL_SRC_HI:`FCS_CTRL_SRC_LO] == `FCS_SRC_KEYPAD) begin
      run_req  = s_r.ctrl[`FCS_CTRL_KRUN];
      want_rev = (s_r.ctrl[`FCS_CTRL_KDIR] == `FCS_KDIR_REVERSE);
    end else begin
      run_req  = s_r.fwd_sync ^ s_r.rvs_sync;
      want_rev = s_r.rvs_sync && !s_r.fwd_sync;
    end

    cmd_lim = i_freq_cmd;
    if (limit_on) begin
      if (i_cmd_at_min && lower_sel != 16'h0000) begin
        cmd_lim = lower_sel;
      end else if (upper_sel != 16'h0000 && i_freq_cmd > upper_sel) begin
        cmd_lim = upper_sel;
      end else if (i_freq_cmd < lower_sel) begin
        cmd_lim = lower_sel;
      end
    end
    // Bipolar input at zero still runs at the lower limit in the chosen direction
    if (i_bipolar_sel && limit_on && i_freq_cmd == 16'h0000 && lower_sel != 16'h0000) begin
      cmd_lim = lower_sel;
    end

    target = jump_fix(jump_fix(jump_fix(cmd_lim, s_r.jc1, s_r.jw1), s_r.jc2, s_r.jw2), s_r.jc3, s_r.jw3);
    if (!run_req || want_rev != s_r.rev) begin
      target = 16'h0000;
    end
    step = (s_r.ramp == 16'h0000) ? 16'h0001 : s_r.ramp;
    tick = (s_r.tick_cnt == 18'(TICK_CYCLES - 1));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;

    // Pin synchronisers
    s_nxt.fwd_meta = i_forward_run_cmd;
    s_nxt.fwd_sync = s_r.fwd_meta;
    s_nxt.rvs_meta = i_reverse_run_cmd;
    s_nxt.rvs_sync = s_r.rvs_meta;

    s_nxt.tick_cnt = tick ? 18'h0_0000 : s_r.tick_cnt + 18'h0_0001;

    // APB: answer in the first access cycle; data and error prepared at setup
    wv       = i_pwdata[15:0];
    wr_ok    = 1'b1;
    unique case (i_paddr)
      `FCS_UPPER1_OFS: wr_ok = upper_ok(wv, s_r.lower1, s_r.maxf);
      `FCS_LOWER1_OFS: wr_ok = lower_ok(wv, s_r.upper1, s_r.maxf, s_r.startf);
      `FCS_UPPER2_OFS: wr_ok = upper_ok(wv, s_r.lower2, s_r.maxf);
      `FCS_LOWER2_OFS: wr_ok = lower_ok(wv, s_r.upper2, s_r.maxf, s_r.startf);
      `FCS_MAXF_OFS:   wr_ok = (wv <= `FCS_FREQ_MAX);
      `FCS_JC1_OFS, `FCS_JC2_OFS, `FCS_JC3_OFS: wr_ok = (wv <= `FCS_FREQ_MAX);
      `FCS_JW1_OFS, `FCS_JW2_OFS, `FCS_JW3_OFS: wr_ok = (wv <= `FCS_WIDTH_MAX);
      `FCS_HOLDF_OFS:  wr_ok = (wv <= `FCS_FREQ_MAX);
      `FCS_HOLDT_OFS:  wr_ok = (wv[9:0] <= `FCS_HOLDT_MAX) && (wv[15:10] == 6'h00);
      `FCS_STATUS_OFS: wr_ok = 1'b0;
      default:         wr_ok = 1'b1;
    endcase
    if (i_psel && !i_penable) begin
      s_nxt.pready  = 1'b1;
      s_nxt.prdata  = i_pwrite ? 32'h0000_0000 : read_word(i_paddr, s_r);
      s_nxt.pslverr = !is_mapped(i_paddr) || (i_pwrite && !wr_ok);
    end else begin
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
    end
    do_write = i_psel && i_penable && s_r.pready && i_pwrite && !s_r.pslverr;
    if (do_write) begin
      unique case (i_paddr)
        `FCS_CTRL_OFS:   s_nxt.ctrl   = i_pwdata[7:0];
        `FCS_UPPER1_OFS: s_nxt.upper1 = wv;
        `FCS_LOWER1_OFS: s_nxt.lower1 = wv;
        `FCS_UPPER2_OFS: s_nxt.upper2 = wv;
        `FCS_LOWER2_OFS: s_nxt.lower2 = wv;
        `FCS_MAXF_OFS:   s_nxt.maxf   = wv;
        `FCS_STARTF_OFS: s_nxt.startf = wv;
        `FCS_JC1_OFS:    s_nxt.jc1    = wv;
        `FCS_JW1_OFS:    s_nxt.jw1    = wv;
        `FCS_JC2_OFS:    s_nxt.jc2    = wv;
        `FCS_JW2_OFS:    s_nxt.jw2    = wv;
        `FCS_JC3_OFS:    s_nxt.jc3    = wv;
        `FCS_JW3_OFS:    s_nxt.jw3    = wv;
        `FCS_HOLDF_OFS:  s_nxt.holdf  = wv;
        `FCS_HOLDT_OFS:  s_nxt.holdt  = wv[9:0];
        `FCS_RAMP_OFS:   s_nxt.ramp   = wv;
        default: begin
        end
      endcase
    end

    // Ramp and acceleration hold, independent of the curve select field
    unique case (s_r.st)
      ST_STOP: begin
        s_nxt.held = 1'b0;
        if (run_req) begin
          s_nxt.rev = want_rev;
          s_nxt.st  = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (tick) begin
          if (s_r.out < target) begin
            // Continuous stepping passes through bands; only the target skips them
            s_nxt.out = (target - s_r.out > step) ? s_r.out + step : target;
            if (!s_r.held && s_r.holdf != 16'h0000 && s_r.out < s_r.holdf
                && s_nxt.out >= s_r.holdf) begin
              s_nxt.out      = s_r.holdf;
              s_nxt.held     = 1'b1;
              s_nxt.hold_cnt = 16'h0000;
              s_nxt.st       = ST_HOLD;
            end
          end else if (s_r.out > target) begin
            s_nxt.out = (s_r.out - target > step) ? s_r.out - step : target;
          end
        end
        if (s_r.out == 16'h0000 && target == 16'h0000) begin
          if (!run_req) begin
            s_nxt.st = ST_STOP;
          end else begin
            s_nxt.rev = want_rev;
          end
        end
      end
      ST_HOLD: begin
        if (!run_req || want_rev != s_r.rev) begin
          s_nxt.st = ST_RAMP;
        end else if (s_r.hold_cnt >= 16'(s_r.holdt * `FCS_HOLD_UNIT_TICKS)) begin
          s_nxt.st = ST_RAMP;
        end else if (tick) begin
          s_nxt.hold_cnt = s_r.hold_cnt + 16'h0001;
        end
      end
      default: s_nxt.st = ST_STOP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r        <= '0;
      s_r.st     <= ST_STOP;
      s_r.ctrl   <= `FCS_CTRL_RST;
      s_r.maxf   <= `FCS_MAXF_RST;
      s_r.startf <= `FCS_STARTF_RST;
      s_r.ramp   <= `FCS_RAMP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_prdata      = s_r.prdata;
  assign o_pready      = s_r.pready;
  assign o_pslverr     = s_r.pslverr;
  assign o_out_freq    = s_r.out;
  assign o_out_reverse = s_r.rev;
  // State codes are chosen so that these two are plain state bits
  assign o_running     = s_r.st[0];
  assign o_accel_hold  = s_r.st[1];

endmodule : frequency_command_shaper

`default_nettype wire

// *** sim/fcs_properties.sv ***
`include "fcs_defines.svh"
`default_nettype none
module fcs_properties (
  // Watched ports
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [15:0] o_out_freq,
  input wire logic        o_out_reverse,
  input wire logic        o_running,
  input wire logic        o_accel_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ramp_r;
  logic [15:0] step;
  logic        wsu;
  assign wsu  = i_psel && !i_penable && i_pwrite;
  assign step = (ramp_r == 16'h0000) ? 16'h0001 : ramp_r;
  // Shadow of the ramp rate, taken from accepted writes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ramp_r <= `FCS_RAMP_RST;
    end else if (i_psel && i_penable && o_pready && !o_pslverr && i_pwrite && i_paddr == `FCS_RAMP_OFS) begin
      ramp_r <= i_pwdata[15:0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  AST_READY_NEXT: assert property (i_psel && !i_penable |=> o_pready) else $error("no answer");
  AST_ERR_QUAL: assert property (o_pslverr |-> o_pready) else $error("stray error");
  AST_UPPER_RANGE: assert property (wsu && i_paddr == `FCS_UPPER1_OFS && i_pwdata[15:0] > `FCS_FREQ_MAX
    |=> o_pslverr) else $error("upper accepted");
  AST_LOWER_RANGE: assert property (wsu && i_paddr == `FCS_LOWER1_OFS && i_pwdata[15:0] > `FCS_FREQ_MAX
    |=> o_pslverr) else $error("lower accepted");
  AST_CENTER_RANGE: assert property (wsu && i_paddr == `FCS_JC1_OFS && i_pwdata[15:0] > `FCS_FREQ_MAX
    |=> o_pslverr) else $error("center accepted");
  AST_WIDTH_RANGE: assert property (wsu && i_paddr == `FCS_JW1_OFS && i_pwdata[15:0] > `FCS_WIDTH_MAX
    |=> o_pslverr) else $error("width accepted");
  AST_RAMP_STEP: assert property ((o_out_freq >= $past(o_out_freq) ? o_out_freq - $past(o_out_freq)
    : $past(o_out_freq) - o_out_freq) <= step) else $error("output stepped");
  AST_HOLD_FREEZE: assert property (o_accel_hold ##1 o_accel_hold |-> $stable(o_out_freq)) else $error("hold moved");
  AST_HOLD_RUN: assert property (o_accel_hold |-> o_running) else $error("hold while stopped");
  AST_STOP_ZERO: assert property (!o_running |-> o_out_freq == 16'h0000) else $error("output while stopped");
  AST_FLIP_ZERO: assert property ($changed(o_out_reverse) |-> $past(o_out_freq) == 16'h0000)
    else $error("flip at speed");
endmodule : fcs_properties
`default_nettype wire

// *** sim/fcs_cmd_source.sv ***
`default_nettype none
module fcs_cmd_source (
  // Bench requests
  input  wire logic        i_clk,
  input  wire logic [15:0] i_cmd,
  input  wire logic        i_amin,
  input  wire logic        i_bip,
  input  wire logic        i_fwd,
  input  wire logic        i_rvs,
  // Toward the shaper
  output logic      [15:0] o_cmd = 16'h0000,
  output logic             o_amin = 1'b0,
  output logic             o_bip = 1'b0,
  output logic             o_fwd = 1'b0,
  output logic             o_rvs = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sources change just after the rising edge
  always @(posedge i_clk) begin
    o_cmd  <= i_cmd;
    o_amin <= i_amin;
    o_bip  <= i_bip;
    o_fwd  <= i_fwd;
    o_rvs  <= i_rvs;
  end
endmodule : fcs_cmd_source
`default_nettype wire

// *** sim/tb_frequency_command_shaper.sv ***
`include "fcs_defines.svh"
`default_nettype none
module tb_frequency_command_shaper;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  localparam logic [7:0]  RA[6] = '{8'h00, 8'h14, 8'h18, 8'h3C, 8'h04, 8'h44};
  localparam logic [31:0] RDV[6] = '{32'h4, 32'h1388, 32'h32, 32'hA, 32'h0, 32'h0};
  localparam logic [7:0]  WA[12] = '{8'h3C, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h04, 8'h1C, 8'h20,
                                     8'h1C, 8'h20};
  localparam logic [15:0] WD[12] = '{16'h100, 16'h1770, 16'h9C41, 16'hBB8, 16'h10, 16'h9C41, 16'h3E8,
                                     16'h3E8, 16'h9C41, 16'h3E9, 16'h7D0, 16'h12C};
  localparam logic [11:0] WE = 12'h3B6;
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h3C35;
  logic [15:0] cmd_q = 16'h0, freq_cmd, out_freq;
  logic        amin_q = 1'b0, bip_q = 1'b0, fwd_q = 1'b0, rvs_q = 1'b0, e, pready, pslverr;
  logic        cmd_at_min, bipolar_sel, fwd, rvs, out_rev, running, hold;
  int          n_mismatch = 0, check_count = 0, u[2], l[2], jc[3], jw[3], k, f;
  bit          m2, third;
  always #2.5 clk = ~clk;
  frequency_command_shaper #(.TICK_CYCLES(TICK)) uut (.i_clk(clk), .i_reset_n(reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_freq_cmd(freq_cmd), .i_cmd_at_min(cmd_at_min),
    .i_bipolar_sel(bipolar_sel), .i_forward_run_cmd(fwd), .i_reverse_run_cmd(rvs), .o_out_freq(out_freq),
    .o_out_reverse(out_rev), .o_running(running), .o_accel_hold(hold));
  fcs_cmd_source src (.i_clk(clk), .i_cmd(cmd_q), .i_amin(amin_q), .i_bip(bip_q), .i_fwd(fwd_q), .i_rvs(rvs_q),
    .o_cmd(freq_cmd), .o_amin(cmd_at_min), .o_bip(bipolar_sel), .o_fwd(fwd), .o_rvs(rvs));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : rnd
  // Steady output expected for a command
  function automatic int tgt(input int c, input bit amin);
    int up, lo, b, bl;
    up = m2 ? u[1] : u[0];
    lo = m2 ? l[1] : l[0];
    if (!third && (up != 0 || lo != 0)) begin
      if (amin && lo != 0) c = lo;
      else if (up != 0 && c > up) c = up;
      else if (c < lo) c = lo;
    end
    for (b = 0; b < 3; b++) begin
      bl = (jc[b] > jw[b]) ? jc[b] - jw[b] : 0;
      if (jc[b] != 0 && jw[b] != 0 && c > bl && c < jc[b] + jw[b]) c = (c >= jc[b]) ? jc[b] + jw[b] : bl;
    end
    return c;
  endfunction : tgt
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    rd = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    apb(1'b1, a, d);
    chk("pslverr", e, x);
  endtask : wr
  task automatic wait_out(input logic [15:0] x);
    int i;
    for (i = 0; i < 4000 && out_freq !== x; i++) @(posedge clk);
    if (out_freq !== x) begin
      n_mismatch++;
      test_done();
    end
    repeat (3 * TICK) @(posedge clk);
  endtask : wait_out
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (k = 0; k < 6; k++) begin
      apb(1'b0, RA[k], 32'h0);
      chk("rdata", rd, RDV[k]);
      chk("rd_err", e, k == 5);
    end
    // Upper is programmed before lower
    for (k = 0; k < 12; k++) wr(WA[k], {16'h0, WD[k]}, WE[k]);
    u[0] = 3000;
    l[0] = 1000;
    jc[0] = 2000;
    jw[0] = 300;
    fwd_q <= 1'b1;
    for (k = 0; k < 6; k++) begin
      seed = rnd(seed);
      cmd_q <= seed[15:0] % 16'h11F8;
      amin_q <= (seed[20:19] == 2'b00);
      f = tgt(seed[15:0] % 16'h11F8, seed[20:19] == 2'b00);
      wait_out(f[15:0]);
      chk("out", out_freq, f);
    end
    {cmd_q, amin_q, bip_q, fwd_q} <= {16'h0, 1'b0, 1'b1, 1'b0};
    wait_out(16'h0);
    for (k = 0; k < 4; k++) begin
      wr(8'h00, k < 2 ? 32'h04 : (k == 2 ? 32'h28 : 32'h38), 1'b0);
      fwd_q <= (k == 0);
      rvs_q <= (k == 1);
      wait_out(16'h3E8);
      chk("out", out_freq, 32'h3E8);
      chk("reverse", out_rev, k[0]);
      {fwd_q, rvs_q} <= 2'b00;
      wr(8'h00, 32'h04, 1'b0);
      wait_out(16'h0);
      chk("running", running, 1'b0);
    end
    {cmd_q, bip_q, fwd_q} <= {16'hFA0, 1'b0, 1'b1};
    for (k = 0; k < 3; k++) begin
      wr(8'h00, k == 0 ? 32'h05 : (k == 1 ? 32'h06 : 32'h04), 1'b0);
      m2 = (k == 0);
      third = (k == 1);
      f = tgt(4000, 1'b0);
      wait_out(f[15:0]);
      chk("out", out_freq, f);
    end
    fwd_q <= 1'b0;
    wait_out(16'h0);
    wr(8'h34, 32'h200, 1'b0);
    wr(8'h38, 32'h1, 1'b0);
    wr(8'h00, 32'hC4, 1'b0);
    {cmd_q, fwd_q} <= {16'h9C4, 1'b1};
    for (k = 0; k < 2000 && hold !== 1'b1; k++) @(posedge clk);
    chk("hold_freq", out_freq, 32'h200);
    for (k = 0; k < 2000 && hold === 1'b1; k++) @(posedge clk);
    chk("hold_time", k >= 100 * TICK && k <= 101 * TICK + 1, 1'b1);
    wait_out(16'h9C4);
    chk("out", out_freq, 32'h9C4);
    test_done();
  end
endmodule : tb_frequency_command_shaper
bind frequency_command_shaper fcs_properties chk_i (.i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_pready, .o_pslverr, .o_out_freq, .o_out_reverse, .o_running, .o_accel_hold);
`default_nettype wire
